// *** src/omc_defs.vh ***
`ifndef OMC_DEFS_VH
`define OMC_DEFS_VH
// ==========================================================
// Register byte offsets
`define OMC_REG_CTRL 4'h0
`define OMC_REG_CHAN 4'h4
`define OMC_REG_MAP0 4'h8
`define OMC_REG_MAP1 4'hc
`define OMC_REG_STAT 5'h10
`define OMC_REG_DIAG 5'h14
// ==========================================================
// Field positions
`define OMC_CTRL_STAY 0
`define OMC_CTRL_SRST 1
`define OMC_STAT_UV 2
`define OMC_STAT_LOP 3
`define OMC_STAT_TER 4
// ==========================================================
// Reset values and limp channel mask
`define OMC_MAP0_RST 4'h4
`define OMC_MAP1_RST 4'h8
`define OMC_LIMP_MASK 4'hc
// ==========================================================
// Mode codes
`define OMC_M_IDLE 2'h0
`define OMC_M_LIMP 2'h1
`define OMC_M_ACT 2'h2
`define OMC_M_SLEEP 2'h3
// ==========================================================
// AXI responses
`define OMC_OKAY 2'h0
`define OMC_SLVERR 2'h2
`endif

// *** src/omc_mode_ctrl.v ***
// Behaviour
// (R1) Four modes: sleep, idle, active, limp; behaviour differs per mode.
// (R2) Mode decided only by wake, direct inputs, channel-on bits, stay-active; the code also uses the supply monitors.
// (R3) Switch-on request outside active goes to active or limp by wake.
// (R4) Sleep: outputs off, all registers held at defaults; the code keeps the fault bits and transmission error.
// (R5) Idle: all channels off, diagnosis inactive.
// (R6) Idle with logic supply: registers work, reads and writes accepted.
// (R7) Idle never clears channel fault bits.
// (R8) Wake high plus any input or channel-on bit enters active.
// (R9) Stay-active 0: all inputs and channel-on low returns to idle.
// (R10) Stay-active 1 holds active regardless of inputs and channel-on bits.
// (R11) Logic supply undervoltage with all inputs low forces idle.
// (R12) High input with wake high enters active even with zero route maps.
// (R13) Wake low and any input high enters limp, driving its channel.
// (R14) Limp: reads return data, writes ignored.
// (R15) Limp: undervoltage and low-power flags read 1, open-load-off reads 0.
// (R16) Limp: mode field reads 01.
// (R17) First command after limp entry sets transmission error, later normal.
// (R18) Limp: fault bits and output monitor bits work normally.
// (R19) Limp: other registers held at default, not programmable.
// (R20) Limp: only channels 2 and 3 switchable.
// (R21) Host avoids commands during active/limp transitions.
// (R22) Power-up needs a supply and an input or wake high.
// (R23) Registers default on logic undervoltage, wake low, soft reset.
// (R24) Direct inputs and wake pin synchronised before use.
`timescale 1ns/100ps
`include "omc_defs.vh"
module omc_mode_ctrl (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Pins and supply monitors
   input wire wake_pin,
   input wire [1:0] direct_input_pins,
   input wire logic_supply_ok,
   input wire load_supply_ok,
   input wire load_supply_uv,
   input wire logic_low_power,
   input wire [3:0] channel_fault_in,
   input wire [3:0] open_load_in,
   input wire [3:0] output_monitor_in,
   // Outputs
   output reg [3:0] channel_drive,
   output reg [1:0] mode_out
);
   // ==========================================================
   // Synchronisers
   // Two stages per pin; stage one is read only by stage two
   wire [18:0] raw;
   reg [18:0] sync1_q;
   reg [18:0] sync2_q;
   assign raw = {output_monitor_in, open_load_in, channel_fault_in,
      logic_low_power, load_supply_uv, load_supply_ok,
      logic_supply_ok, direct_input_pins, wake_pin};
   // (R24) Two-flop sync
   always @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= 19'h00000;
         sync2_q <= 19'h00000;
      end else begin
         sync1_q <= raw;
         sync2_q <= sync1_q;
      end
   end
   wire wake_s = sync2_q[0];
   wire [1:0] in_s = sync2_q[2:1];
   wire vdd_ok_s = sync2_q[3];
   wire vs_ok_s = sync2_q[4];
   wire vs_uv_s = sync2_q[5];
   wire lop_s = sync2_q[6];
   wire [3:0] fault_s = sync2_q[10:7];
   wire [3:0] ol_s = sync2_q[14:11];
   wire [3:0] mon_s = sync2_q[18:15];
   // ==========================================================
   // Registers and AXI state
   reg [1:0] mode_q;
   reg [1:0] mode_d;
   reg stay_q;
   reg [3:0] chan_q;
   reg [3:0] map0_q;
   reg [3:0] map1_q;
   reg uv_flag_q;
   reg lop_flag_q;
   reg ter_q;
   reg limp_first_q;
   reg [3:0] fault_q;
   reg [3:0] open_load_off_bits_q;
   reg aw_have_q;
   reg w_have_q;
   reg [4:0] aw_addr_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   wire any_in = |in_s;
   wire limp = (mode_q == `OMC_M_LIMP);
   wire active = (mode_q == `OMC_M_ACT);
   // (R22) Power-up condition
   wire power_up = (vdd_ok_s | vs_ok_s) & (any_in | wake_s);
   // ==========================================================
   // Mode state machine
   // (R2) Wake, inputs, channel bits, stay bit, plus supply monitors
   always @* begin
      mode_d = mode_q;
      case (mode_q)
         `OMC_M_SLEEP: begin
            // (R3) Request leaves sleep
            if (power_up && wake_s && (any_in || stay_q))
               mode_d = `OMC_M_ACT;
            else if (power_up && wake_s)
               mode_d = `OMC_M_IDLE;
            else if (power_up && any_in)
               mode_d = `OMC_M_LIMP;
         end
         `OMC_M_IDLE: begin
            // (R8) Enter active; (R12) maps ignored here
            if (!power_up)
               mode_d = `OMC_M_SLEEP;
            else if (!wake_s)
               mode_d = `OMC_M_LIMP;
            else if (any_in || (|chan_q) || stay_q)
               mode_d = `OMC_M_ACT;
         end
         `OMC_M_ACT: begin
            if (!power_up)
               mode_d = `OMC_M_SLEEP;
            // (R13) Wake low with input high
            else if (!wake_s)
               mode_d = any_in ? `OMC_M_LIMP : `OMC_M_SLEEP;
            // (R11) Logic undervoltage to idle
            else if (!vdd_ok_s && !any_in)
               mode_d = `OMC_M_IDLE;
            // (R9) Fall back; (R10) stay bit holds
            else if (!stay_q && !any_in && !(|chan_q))
               mode_d = `OMC_M_IDLE;
         end
         `OMC_M_LIMP: begin
            if (!power_up)
               mode_d = `OMC_M_SLEEP;
            // (R3) Wake high returns to active
            else if (wake_s)
               mode_d = `OMC_M_ACT;
            else if (!any_in)
               mode_d = `OMC_M_SLEEP;
         end
         default: mode_d = `OMC_M_SLEEP;
      endcase
   end
   // (R1) Mode register
   always @(posedge aclk) begin
      if (!aresetn)
         mode_q <= `OMC_M_SLEEP;
      else
         mode_q <= mode_d;
   end
   // ==========================================================
   // Channel drive
   wire [3:0] routed = (in_s[0] ? map0_q : 4'h0) |
      (in_s[1] ? map1_q : 4'h0);
   always @(posedge aclk) begin
      if (!aresetn)
         channel_drive <= 4'h0;
      else if (active)
         channel_drive <= chan_q | routed;
      // (R20) Limp drives channels 2 and 3 only
      else if (limp)
         channel_drive <= routed & `OMC_LIMP_MASK;
      // (R4) (R5) Sleep and idle off
      else
         channel_drive <= 4'h0;
   end
   // ==========================================================
   // Write path
   // Address and data may come in either order
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;
   wire ar_take = s_axi_arvalid & s_axi_arready;
   wire wr_map = (aw_addr_q[4:2] <= 3'h5);
   // (R6) (R14) Writes only outside limp and sleep
   wire wr_ok = wr_go & wr_map & ~limp & (mode_q != `OMC_M_SLEEP);
   wire wr_ctrl = wr_ok & (aw_addr_q == {1'b0, `OMC_REG_CTRL});
   wire wr_chan = wr_ok & (aw_addr_q == {1'b0, `OMC_REG_CHAN});
   wire wr_map0 = wr_ok & (aw_addr_q == {1'b0, `OMC_REG_MAP0});
   wire wr_map1 = wr_ok & (aw_addr_q == {1'b0, `OMC_REG_MAP1});
   wire wr_diag = wr_ok & (aw_addr_q == `OMC_REG_DIAG);
   wire soft_rst = wr_ctrl & w_strb_q[0] & w_data_q[`OMC_CTRL_SRST];
   // (R4) (R19) (R23) Default-holding conditions
   wire reg_clr = (mode_q == `OMC_M_SLEEP) | !vdd_ok_s | !wake_s |
      soft_rst;
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 5'h00;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `OMC_OKAY;
      end else begin
         s_axi_awready <= ~aw_have_q & ~aw_take;
         s_axi_wready <= ~w_have_q & ~w_take;
         if (aw_take) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr[4:0];
         end
         if (w_take) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_map ? `OMC_OKAY : `OMC_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   // ==========================================================
   // Control registers
   always @(posedge aclk) begin
      if (!aresetn || reg_clr) begin
         stay_q <= 1'b0;
         chan_q <= 4'h0;
         map0_q <= `OMC_MAP0_RST;
         map1_q <= `OMC_MAP1_RST;
      end else begin
         if (wr_ctrl && w_strb_q[0])
            stay_q <= w_data_q[`OMC_CTRL_STAY];
         if (wr_chan && w_strb_q[0])
            chan_q <= w_data_q[3:0];
         if (wr_map0 && w_strb_q[0])
            map0_q <= w_data_q[3:0];
         if (wr_map1 && w_strb_q[0])
            map1_q <= w_data_q[3:0];
      end
   end
   // ==========================================================
   // Diagnosis
   wire rd_stat = ar_take &
      (s_axi_araddr[4:0] == `OMC_REG_STAT);
   wire diag_on = active | limp;
   wire diag_clr = wr_diag & w_strb_q[0];
   // (R7) (R18) Fault bits survive idle and soft reset; set wins
   always @(posedge aclk) begin
      if (!aresetn || !vdd_ok_s)
         fault_q <= 4'h0;
      else
         fault_q <= (fault_q & ~(diag_clr ? w_data_q[3:0] : 4'h0)) |
            (diag_on ? fault_s : 4'h0);
   end
   // (R5) Off-state open load sampled only when diagnosing
   always @(posedge aclk) begin
      if (!aresetn || reg_clr)
         open_load_off_bits_q <= 4'h0;
      else if (active)
         open_load_off_bits_q <= ol_s & ~channel_drive;
   end
   // Supply flags clear on status read once condition gone
   // (R23) Soft reset clears both supply flags while neither supply condition is present
   always @(posedge aclk) begin
      if (!aresetn || (reg_clr && !vs_uv_s && !lop_s)) begin
         uv_flag_q <= 1'b0;
         lop_flag_q <= 1'b0;
      end else begin
         if (vs_uv_s)
            uv_flag_q <= 1'b1;
         else if (rd_stat)
            uv_flag_q <= 1'b0;
         if (lop_s)
            lop_flag_q <= 1'b1;
         else if (rd_stat)
            lop_flag_q <= 1'b0;
      end
   end
   // ==========================================================
   // Transmission error
   // Set by unmapped access, cleared by status read; set wins
   wire rd_bad = ar_take & (s_axi_araddr[4:2] > 3'h5);
   wire any_cmd = ar_take | wr_go;
   // (R17) First command after limp entry flags error
   wire limp_hit = limp_first_q & any_cmd & ~rd_stat;
   wire ter_set = rd_bad | (wr_go & ~wr_map) | limp_hit;
   always @(posedge aclk) begin
      if (!aresetn) begin
         ter_q <= 1'b0;
         limp_first_q <= 1'b0;
      end else begin
         if (ter_set)
            ter_q <= 1'b1;
         else if (rd_stat)
            ter_q <= 1'b0;
         if (mode_d == `OMC_M_LIMP && !limp)
            limp_first_q <= 1'b1;
         else if (any_cmd || !limp)
            limp_first_q <= 1'b0;
      end
   end
   // ==========================================================
   // Read path
   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h00000000;
      case (s_axi_araddr[4:2])
         3'h0: rd_mux[0] = stay_q;
         3'h1: rd_mux[3:0] = chan_q;
         3'h2: rd_mux[3:0] = map0_q;
         3'h3: rd_mux[3:0] = map1_q;
         3'h4: begin
            // (R16) Mode field reports limp as 01
            rd_mux[1:0] = mode_q;
            // (R15) Limp forces supply flags high
            rd_mux[`OMC_STAT_UV] = uv_flag_q | limp;
            rd_mux[`OMC_STAT_LOP] = lop_flag_q | limp;
            rd_mux[`OMC_STAT_TER] = ter_q | limp_first_q;
            rd_mux[11:8] = channel_drive;
         end
         3'h5: begin
            rd_mux[3:0] = fault_q;
            // (R15) Open-load-off reads 0 in limp
            rd_mux[7:4] = limp ? 4'h0 : open_load_off_bits_q;
            // (R18) Monitor live in limp
            rd_mux[11:8] = mon_s;
         end
         default: rd_mux = 32'h00000000;
      endcase
   end
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `OMC_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~ar_take;
         if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_bad ? `OMC_SLVERR : `OMC_OKAY;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
   always @(posedge aclk) begin
      if (!aresetn)
         mode_out <= `OMC_M_SLEEP;
      else
         mode_out <= mode_d;
   end
endmodule

// *** sim/omc_mode_ctrl_properties.sv ***
`timescale 1ns/100ps
module omc_mode_props (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Bus handshakes
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arready,
   input wire s_axi_arvalid,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   // Outputs
   input wire [3:0] channel_drive,
   input wire [1:0] mode_out
);
   // ==========
   // Mode history
   reg [1:0] m1_q;
   reg [1:0] m2_q;
   wire st;
   always @(posedge aclk) begin
      m1_q <= mode_out;
      m2_q <= m1_q;
   end
   // Drive lags mode, so judge only settled modes
   assign st = mode_out == m1_q && m1_q == m2_q;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_sleep_drive_off: assert property (
      st && mode_out == 2'h3 |-> channel_drive == 4'h0)
      else $error("channel on in sleep");
   a_idle_drive_off: assert property (
      st && mode_out == 2'h0 |-> channel_drive == 4'h0)
      else $error("channel on in idle");
   a_limp_low_off: assert property (
      st && mode_out == 2'h1 |-> channel_drive[1:0] == 2'h0)
      else $error("low channel on in limp");
   a_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("no write response");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("no read response");
   a_bresp_stands: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rdata_stands: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_read_blocks: assert property (
      s_axi_rvalid |-> !s_axi_arready)
      else $error("second read taken early");
endmodule
bind omc_mode_ctrl omc_mode_props u_props (.aclk, .aresetn,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready,
   .s_axi_arvalid, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .channel_drive, .mode_out);

// *** sim/omc_pin_host.sv ***
`timescale 1ns/100ps
module omc_pin_host (
   // Clock
   input wire aclk,
   // Requested levels
   input wire q_wake,
   input wire [1:0] q_din,
   input wire q_lok,
   input wire [3:0] q_mon,
   // Pins toward the device
   output reg wake_pin = 1'b0,
   output reg [1:0] direct_input_pins = 2'h0,
   output reg logic_supply_ok = 1'b0,
   output reg load_supply_ok = 1'b0,
   output reg [3:0] output_monitor_in = 4'h0
);
   // Pins move only just after an edge, like a host port
   always @(posedge aclk) begin
      wake_pin <= q_wake;
      direct_input_pins <= q_din;
      logic_supply_ok <= q_lok;
      load_supply_ok <= 1'b1;
      output_monitor_in <= q_mon;
   end
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
   // ==========
   // Signals
   reg aclk = 1'b0;
   reg aresetn = 1'b0;
   reg [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
   reg [31:0] s_axi_araddr = 32'h0;
   reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid;
   wire s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp, mode_out;
   wire [31:0] s_axi_rdata;
   wire [3:0] channel_drive, output_monitor_in;
   wire wake_pin, logic_supply_ok, load_supply_ok;
   wire [1:0] direct_input_pins;
   reg q_wake = 1'b1, q_lok = 1'b1;
   reg [1:0] q_din = 2'h0;
   reg [3:0] q_mon = 4'h0;
   reg [3:0] q_flt = 4'h0;
   int bad_count = 0, checked = 0, cyc = 0;
   always #50 aclk = ~aclk;
   omc_pin_host u_host (.aclk, .q_wake, .q_din, .q_lok, .q_mon,
      .wake_pin, .direct_input_pins, .logic_supply_ok, .load_supply_ok,
      .output_monitor_in);
   omc_mode_ctrl DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wake_pin,
      .direct_input_pins, .logic_supply_ok, .load_supply_ok,
      .load_supply_uv(1'b0), .logic_low_power(1'b0),
      .channel_fault_in(q_flt), .open_load_in(4'h0), .output_monitor_in,
      .channel_drive, .mode_out);
   // ==========
   // Tasks
   task close_out;
      begin
         $display("checked=%0d bad_count=%0d", checked, bad_count);
         if (bad_count == 0 && checked > 0) begin
            $display("Result: passed");
         end else begin
            $display("Result: failed");
         end
         $finish;
      end
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      begin
         checked = checked + 1;
         if (g !== e) begin
            bad_count = bad_count + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   task wr(input [31:0] a, input [31:0] d, input [1:0] er);
      begin
         @(posedge aclk);
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
         end while (!s_axi_bvalid);
         s_axi_bready <= 1'b0;
         chk({30'h0, s_axi_bresp}, {30'h0, er});
      end
   endtask
   task rd(input [31:0] a, input [31:0] e, input [1:0] er);
      begin
         @(posedge aclk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
         end while (!s_axi_rvalid);
         s_axi_rready <= 1'b0;
         chk(s_axi_rdata, e);
         chk({30'h0, s_axi_rresp}, {30'h0, er});
      end
   endtask
   task pins(input w, input [1:0] d, input l, input [3:0] m);
      begin
         @(posedge aclk);
         q_wake <= w;
         q_din <= d;
         q_lok <= l;
         q_mon <= m;
      end
   endtask
   task wm(input [1:0] e);
      int n;
      begin
         n = 0;
         while (mode_out !== e && n < 30) begin
            @(posedge aclk);
            n = n + 1;
         end
         repeat (3) @(posedge aclk);
         chk({30'h0, mode_out}, {30'h0, e});
      end
   endtask
   task drv(input [3:0] e);
      chk({28'h0, channel_drive}, {28'h0, e});
   endtask
   // ==========
   // Hang guard
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count = bad_count + 1;
         close_out;
      end
   end
   // ==========
   // Tests
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      wm(2'h0);
      rd(32'h8, 32'h4, 2'h0);
      rd(32'hc, 32'h8, 2'h0);
      $display("test powerup done");
      wr(32'h4, 32'h5, 2'h0);
      wm(2'h2);
      drv(4'h5);
      rd(32'h10, 32'h502, 2'h0);
      wr(32'h0, 32'h1, 2'h0);
      wr(32'h4, 32'h0, 2'h0);
      wm(2'h2);
      wr(32'h0, 32'h0, 2'h0);
      wm(2'h0);
      drv(4'h0);
      $display("test stay done");
      wr(32'h4, 32'h1, 2'h0);
      wm(2'h2);
      q_flt <= 4'h2;
      repeat (4) @(posedge aclk);
      q_flt <= 4'h0;
      wr(32'h4, 32'h0, 2'h0);
      wm(2'h0);
      rd(32'h14, 32'h2, 2'h0);
      wr(32'h8, 32'h1, 2'h0);
      wr(32'h0, 32'h2, 2'h0);
      rd(32'h14, 32'h2, 2'h0);
      rd(32'h8, 32'h4, 2'h0);
      wr(32'h14, 32'h2, 2'h0);
      rd(32'h14, 32'h0, 2'h0);
      $display("test fault done");
      wr(32'h8, 32'h0, 2'h0);
      wr(32'hc, 32'h0, 2'h0);
      pins(1'b1, 2'h1, 1'b1, 4'h0);
      wm(2'h2);
      drv(4'h0);
      pins(1'b1, 2'h0, 1'b1, 4'h0);
      wm(2'h0);
      wr(32'h0, 32'h1, 2'h0);
      wm(2'h2);
      pins(1'b1, 2'h0, 1'b0, 4'h0);
      wm(2'h0);
      pins(1'b1, 2'h0, 1'b1, 4'h0);
      wm(2'h0);
      $display("test maps done");
      pins(1'b0, 2'h2, 1'b1, 4'ha);
      wm(2'h1);
      drv(4'h8);
      rd(32'h10, 32'h81d, 2'h0);
      rd(32'h10, 32'h80d, 2'h0);
      rd(32'h14, 32'ha00, 2'h0);
      wr(32'h4, 32'hf, 2'h0);
      rd(32'h4, 32'h0, 2'h0);
      drv(4'h8);
      $display("test limp done");
      pins(1'b0, 2'h0, 1'b1, 4'h0);
      wm(2'h3);
      drv(4'h0);
      pins(1'b1, 2'h0, 1'b1, 4'h0);
      wm(2'h0);
      rd(32'h8, 32'h4, 2'h0);
      rd(32'h18, 32'h0, 2'h2);
      wr(32'h1c, 32'h0, 2'h2);
      $display("test sleep done");
      close_out;
   end
endmodule
